/* logic/hmsc_ctrl.sv */
// Haptic playback state machine, mode selection and host-streamed drive level path
`timescale 1ns/1ps
`include "hmsc_defs.svh"
module hmsc_ctrl
    import hmsc_pkg::*;
#(
    parameter int HALF_W = 20,
    parameter int BOOT_CYC = `HMSC_BOOT_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Register port
    input wire logic [`HMSC_ADDR_W-1:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // Pin and companion blocks
    input wire logic TRIGGER_PWM_PIN,
    input wire logic [7:0] FAULT_FLAGS,
    input wire logic STORED_DONE,
    input wire logic ZERO_CROSS,
    // Drive outputs
    output hmsc_drive_type DRIVE,
    output hmsc_loop_type LOOP,
    output hmsc_state_type STATE,
    output logic STORED_START
);
    localparam int PWM_W = `HMSC_PWM_CNT_W;
    hmsc_state_type state_ff;
    logic [15:0] ctrl_ff;
    logic [7:0] level_ff;
    logic [7:0] nom_ff;
    logic [7:0] abs_ff;
    logic [HALF_W-1:0] half_ff;
    logic [15:0] boot_cnt_ff;
    logic [2:0] pin_sync_ff;
    logic [`HMSC_PWM_CNT_W-1:0] pwm_hi_ff;
    logic [`HMSC_PWM_CNT_W-1:0] pwm_per_ff;
    logic [7:0] pwm_level_ff;
    logic stored_run_ff;
    logic pol_ff;
    logic drive_en_ff;
    logic [HALF_W-1:0] reen_cnt_ff;
    logic [7:0] applied_ff;
    logic [15:0] level_out_ff;
    logic [7:0] fault_ff;
    hmsc_mode_type mode;
    logic standby_sel;
    logic accel_en;
    logic fault_any;
    logic pin_rise;
    logic pin_fall;
    logic pin_edge;
    logic go_write;
    logic stream_mode;
    logic start_req;
    logic [7:0] src_level;
    logic [7:0] mag;
    logic [15:0] nxt_level;
    logic [1:0] edge_cfg;
    logic [2:0] mode_field;
    logic raw_req;
    logic waiting;
    logic in_drive;
    logic boot_done;
    logic level_zero;
    logic [23:0] pwm_ratio;
    logic [15:0] nxt_rdata;

    // Mode field above 4 collapses to the inactive mode
    always_comb begin
        case (mode_field)
            3'h1: mode = HMSC_MODE_STREAM;
            3'h2: mode = HMSC_MODE_PWM;
            3'h3: mode = HMSC_MODE_REG_TRIG;
            3'h4: mode = HMSC_MODE_EDGE_TRIG;
            default: mode = HMSC_MODE_OFF;
        endcase
    end

    // Control field decode and state shorthands
    assign mode_field = ctrl_ff[`HMSC_CTRL_MODE_LSB +: 3];
    assign waiting = (state_ff == HMSC_ST_IDLE) || (state_ff == HMSC_ST_STANDBY);
    assign in_drive = state_ff == HMSC_ST_DRIVE;
    assign level_zero = nxt_level == 16'h0000;
    assign standby_sel = ctrl_ff[`HMSC_CTRL_STBY_BIT];
    assign accel_en = ctrl_ff[`HMSC_CTRL_ACCEL_BIT];
    assign edge_cfg = ctrl_ff[`HMSC_CTRL_EDGE_LSB +: 2];
    assign fault_any = |fault_ff;
    assign go_write = WR && (ADDR == `HMSC_REG_GO) && WDATA[0];
    assign stream_mode = (mode == HMSC_MODE_STREAM) || (mode == HMSC_MODE_PWM);

    // Fault levels come from a block on this clock; one register stage
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            fault_ff <= 8'h00;
        end else begin
            fault_ff <= FAULT_FLAGS;
        end
    end

    // Pin synchroniser plus one stage for edge detection
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pin_sync_ff <= 3'h0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[1:0], TRIGGER_PWM_PIN};
        end
    end

    assign pin_rise = pin_sync_ff[1] && !pin_sync_ff[2];
    assign pin_fall = !pin_sync_ff[1] && pin_sync_ff[2];

    // Edge selection: 0 rising, 1 falling, 2 both
    always_comb begin
        case (edge_cfg)
            2'h0: pin_edge = pin_rise;
            2'h1: pin_edge = pin_fall;
            2'h2: pin_edge = pin_rise || pin_fall;
            default: pin_edge = 1'b0;
        endcase
    end

    // Playback request per mode, honoured only with faults clear
    always_comb begin
        case (mode)
            HMSC_MODE_STREAM: raw_req = 1'b1;
            HMSC_MODE_PWM: raw_req = 1'b1;
            HMSC_MODE_REG_TRIG: raw_req = go_write;
            HMSC_MODE_EDGE_TRIG: raw_req = go_write || pin_edge;
            default: raw_req = 1'b0;
        endcase
    end

    assign start_req = raw_req && !fault_any;

    // Boot delay counter; it only runs while the machine is in boot
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            boot_cnt_ff <= 16'h0000;
        end else if (state_ff == HMSC_ST_BOOT) begin
            boot_cnt_ff <= boot_cnt_ff + 16'h0001;
        end
    end

    assign boot_done = boot_cnt_ff == 16'(BOOT_CYC - 1);

    // System state machine
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_ff <= HMSC_ST_BOOT;
        end else begin
            case (state_ff)
                HMSC_ST_BOOT: begin
                    if (boot_done) begin
                        state_ff <= HMSC_ST_IDLE;
                    end
                end
                HMSC_ST_IDLE, HMSC_ST_STANDBY: begin
                    if (fault_any) begin
                        state_ff <= HMSC_ST_IDLE;
                    end else if (start_req) begin
                        state_ff <= HMSC_ST_DRIVE;
                    end else begin
                        state_ff <= standby_sel ? HMSC_ST_STANDBY : HMSC_ST_IDLE;
                    end
                end
                HMSC_ST_DRIVE: begin
                    if (fault_any) begin
                        state_ff <= HMSC_ST_IDLE;
                    end else if ((stream_mode == 1'b0 && !stored_run_ff) || mode == HMSC_MODE_OFF) begin
                        state_ff <= standby_sel ? HMSC_ST_STANDBY : HMSC_ST_IDLE;
                    end
                end
                default: state_ff <= HMSC_ST_IDLE;
            endcase
        end
    end

    // Stored-waveform run flag; in edge-trigger mode a configured pin edge during playback stops it
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            stored_run_ff <= 1'b0;
        end else if (waiting && start_req && !stream_mode) begin
            stored_run_ff <= 1'b1;
        end else if (fault_any || STORED_DONE) begin
            stored_run_ff <= 1'b0;
        end else if (stored_run_ff && mode == HMSC_MODE_EDGE_TRIG && pin_edge) begin
            stored_run_ff <= 1'b0;
        end
    end

    assign STORED_START = waiting && start_req && !stream_mode;

    // Register writes; values kept through idle and standby
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_ff <= `HMSC_CTRL_RESET;
            level_ff <= 8'h00;
            nom_ff <= `HMSC_NOMPK_RESET;
            abs_ff <= `HMSC_ABSPK_RESET;
            half_ff <= HALF_W'(`HMSC_HALF_RESET);
        end else if (WR) begin
            case (ADDR)
                `HMSC_REG_CTRL: ctrl_ff <= WDATA;
                `HMSC_REG_LEVEL: level_ff <= WDATA[7:0];
                `HMSC_REG_NOMPK: nom_ff <= WDATA[7:0];
                `HMSC_REG_ABSPK: abs_ff <= WDATA[7:0];
                `HMSC_REG_HALF: half_ff <= HALF_W'(WDATA) << 4;
                default: ;
            endcase
        end
    end

    // Duty as a fraction of 256; a period that is high throughout gives 256
    assign pwm_ratio = ({8'h00, pwm_hi_ff} << 8) / {8'h00, pwm_per_ff};

    // PWM demodulator: duty cycle measured between rising edges
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pwm_hi_ff <= '0;
            pwm_per_ff <= '0;
            pwm_level_ff <= 8'h00;
        end else if (pin_rise) begin
            // The rising cycle is high and is the first cycle of the next period
            pwm_hi_ff <= PWM_W'(1);
            pwm_per_ff <= PWM_W'(1);
            if (pwm_per_ff != '0) begin
                if (pwm_ratio > 24'h0000ff) begin
                    pwm_level_ff <= 8'hff;
                end else begin
                    pwm_level_ff <= pwm_ratio[7:0];
                end
            end
        end else if (pwm_per_ff != '1) begin
            pwm_per_ff <= pwm_per_ff + 1'b1;
            if (pin_sync_ff[1]) begin
                pwm_hi_ff <= pwm_hi_ff + 1'b1;
            end
        end
    end

    // Source level as signed code: PWM duty mapped to the same scale
    always_comb begin
        if (mode == HMSC_MODE_PWM) begin
            src_level = accel_en ? {1'b0, pwm_level_ff[7:1]} : (pwm_level_ff ^ 8'h80);
        end else begin
            src_level = level_ff;
        end
    end

    // Magnitude and scaling against the selected peak voltage
    always_comb begin
        if (accel_en) begin
            mag = src_level[7] ? 8'h00 : src_level;
            nxt_level = ({8'h00, mag} * {8'h00, nom_ff}) << 1;
        end else begin
            mag = src_level[7] ? 8'((~src_level) + 8'h01) : src_level;
            if (mag == 8'h80) begin
                mag = 8'h7f;
            end
            nxt_level = ({8'h00, mag} * {8'h00, abs_ff}) << 1;
        end
    end

    // Amplitude and polarity applied only at zero crossings
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            applied_ff <= 8'h00;
            level_out_ff <= 16'h0000;
        end else if (!in_drive) begin
            applied_ff <= 8'h00;
            level_out_ff <= 16'h0000;
        end else if (ZERO_CROSS) begin
            applied_ff <= src_level;
            level_out_ff <= nxt_level;
        end
    end

    // Polarity of the level applied at the last crossing, kept between playbacks
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pol_ff <= 1'b0;
        end else if (in_drive && ZERO_CROSS) begin
            pol_ff <= !accel_en && src_level[7];
        end
    end

    // Output stage gating with half-period re-enable delay
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            drive_en_ff <= 1'b0;
            reen_cnt_ff <= '0;
        end else if (!in_drive || level_zero) begin
            drive_en_ff <= 1'b0;
            reen_cnt_ff <= '0;
        end else if (!drive_en_ff) begin
            if (reen_cnt_ff >= half_ff) begin
                drive_en_ff <= 1'b1;
            end else begin
                reen_cnt_ff <= reen_cnt_ff + 1'b1;
            end
        end
    end

    // Loop feature enables: open loop forces all off
    always_comb begin
        LOOP.bemf_en = ctrl_ff[`HMSC_CTRL_CLOSED_BIT];
        LOOP.ftrack_en = LOOP.bemf_en && ctrl_ff[`HMSC_CTRL_FTRK_BIT];
        LOOP.accel_en = LOOP.bemf_en && accel_en;
        LOOP.rstop_en = LOOP.bemf_en && ctrl_ff[`HMSC_CTRL_RSTOP_BIT];
        LOOP.amp_en = LOOP.bemf_en && ctrl_ff[`HMSC_CTRL_AMP_BIT];
    end

    assign DRIVE.level = level_out_ff;
    assign DRIVE.negative = pol_ff;
    assign DRIVE.enable = drive_en_ff && level_out_ff != 16'h0000;
    assign STATE = state_ff;

    // Read mux; the flop below holds the word only for the cycle after the strobe
    always_comb begin
        case (ADDR)
            `HMSC_REG_CTRL: nxt_rdata = ctrl_ff;
            `HMSC_REG_LEVEL: nxt_rdata = {8'h00, level_ff};
            `HMSC_REG_NOMPK: nxt_rdata = {8'h00, nom_ff};
            `HMSC_REG_ABSPK: nxt_rdata = {8'h00, abs_ff};
            `HMSC_REG_STAT: nxt_rdata = {5'h00, stored_run_ff, drive_en_ff, mode, applied_ff[7:4], state_ff};
            `HMSC_REG_FAULT: nxt_rdata = {8'h00, fault_ff};
            `HMSC_REG_POL: nxt_rdata = {15'h0000, pol_ff};
            `HMSC_REG_HALF: nxt_rdata = 16'(half_ff >> 4);
            default: nxt_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            RDATA <= nxt_rdata;
        end else begin
            RDATA <= 16'h0000;
        end
    end
endmodule

/* logic/hmsc_defs.svh */
// Register offsets, field positions, reset values and timing counts of the playback controller
// Functional notes
// - After reset, load register defaults, finish boot, then wait in idle.
// - Enter drive state when playback of a sequence begins, in any mode.
// - On playback completion go to standby if standby-select set, else idle.
// - Any fault sends the state machine straight to idle; the code ignores faults during boot.
// - Mode 0: no playback, wait in idle or standby per standby-select.
// - Mode 1: play the host-streamed drive level register.
// - Mode 2: take drive level from the trigger/PWM pin duty cycle.
// - Mode 3: start stored playback only on a host sequence_go write.
// - Mode 4: start stored playback on configured pin edge or sequence_go.
// - Registers keep their values in idle and standby.
// - Stay inactive until a request; honour it only with all faults cleared.
// - Host drive level is a two's complement signed fraction of full scale.
// - Acceleration on: level times nominal peak, 0x00..0x7f; 0x80..0xff unused.
// - With acceleration, steady-state level scales to nominal peak voltage.
// - Acceleration off: level times absolute peak, -100% at 0x80 to +100%.
// - Negative level reverses polarity (rotating mass) or shifts phase 180 (resonant).
// - New amplitude sampled only at drive zero crossings, twice per period.
// - Host write reaches output within one half period; polarity is readable.
// - Zero level disables output stage; re-enable one half period after non-zero.
// - Open loop disables back-EMF monitoring and all auto adjustment.
// - Closed loop: tracking, acceleration, rapid stop, amplitude each enableable.
`ifndef HMSC_DEFS_SVH
`define HMSC_DEFS_SVH
`define HMSC_ADDR_W 4
`define HMSC_REG_CTRL 4'h0
`define HMSC_REG_LEVEL 4'h1
`define HMSC_REG_NOMPK 4'h2
`define HMSC_REG_ABSPK 4'h3
`define HMSC_REG_GO 4'h4
`define HMSC_REG_STAT 4'h5
`define HMSC_REG_FAULT 4'h6
`define HMSC_REG_POL 4'h7
`define HMSC_REG_HALF 4'h8
// Control register fields
`define HMSC_CTRL_MODE_LSB 0
`define HMSC_CTRL_STBY_BIT 3
`define HMSC_CTRL_ACCEL_BIT 4
`define HMSC_CTRL_ERM_BIT 5
`define HMSC_CTRL_CLOSED_BIT 6
`define HMSC_CTRL_FTRK_BIT 7
`define HMSC_CTRL_RSTOP_BIT 8
`define HMSC_CTRL_AMP_BIT 9
`define HMSC_CTRL_EDGE_LSB 10
`define HMSC_CTRL_RESET 16'h0000
`define HMSC_NOMPK_RESET 8'h40
`define HMSC_ABSPK_RESET 8'h60
// Half period default in clock cycles (one half of 170 Hz period at 25 MHz)
`define HMSC_HALF_RESET 20'h11f4a
`define HMSC_BOOT_NS 1000
`define HMSC_CLK_NS 40
`define HMSC_BOOT_CYC ((`HMSC_BOOT_NS + `HMSC_CLK_NS - 1) / `HMSC_CLK_NS)
`define HMSC_PWM_CNT_W 16
`endif

/* logic/hmsc_pkg.sv */
// Types shared by the playback controller
package hmsc_pkg;
    typedef enum logic [2:0] {
        HMSC_MODE_OFF = 3'h0,
        HMSC_MODE_STREAM = 3'h1,
        HMSC_MODE_PWM = 3'h2,
        HMSC_MODE_REG_TRIG = 3'h3,
        HMSC_MODE_EDGE_TRIG = 3'h4
    } hmsc_mode_type;
    typedef enum logic [1:0] {
        HMSC_ST_BOOT = 2'h0,
        HMSC_ST_IDLE = 2'h1,
        HMSC_ST_STANDBY = 2'h2,
        HMSC_ST_DRIVE = 2'h3
    } hmsc_state_type;
    typedef struct packed {
        logic [15:0] level;
        logic negative;
        logic enable;
    } hmsc_drive_type;
    typedef struct packed {
        logic bemf_en;
        logic ftrack_en;
        logic accel_en;
        logic rstop_en;
        logic amp_en;
    } hmsc_loop_type;
endpackage

/* sim/hmsc_stage_model.sv */
// Stand-in for the output stage and waveform sequencer: zero-crossing pulses and sequence completion
`timescale 1ns/1ps
module hmsc_stage_model #(
    parameter int ZC_PER = 12,
    parameter int RUN_CYC = 20
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Controller side
    input wire logic STORED_START,
    output logic ZERO_CROSS,
    output logic STORED_DONE
);
    int zc_ff;
    int run_ff;
    // Zero crossings arrive twice per resonant period, one cycle wide
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            zc_ff <= 0;
            ZERO_CROSS <= 1'b0;
        end else begin
            zc_ff <= (zc_ff == ZC_PER - 1) ? 0 : zc_ff + 1;
            ZERO_CROSS <= (zc_ff == ZC_PER - 1);
        end
    end
    // A started sequence runs a fixed span, then reports completion
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            run_ff <= 0;
            STORED_DONE <= 1'b0;
        end else begin
            run_ff <= STORED_START ? RUN_CYC : (run_ff > 0 ? run_ff - 1 : 0);
            STORED_DONE <= (run_ff == 1) && !STORED_START;
        end
    end
endmodule

/* sim/hmsc_ctrl_checker.sv */
// Concurrent checks on the playback controller ports
`timescale 1ns/1ps
module hmsc_ctrl_checker
    import hmsc_pkg::*;
#(
    parameter int HALF_W = 20,
    parameter int BOOT_CYC = 25
) (
    // Watched ports
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] FAULT_FLAGS,
    input wire logic ZERO_CROSS,
    input wire hmsc_drive_type DRIVE,
    input wire hmsc_state_type STATE,
    input wire logic STORED_START
);
    localparam int BOOT_MAX = BOOT_CYC + 2;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    AST_BOOT_END: assert property (STATE == HMSC_ST_BOOT |-> ##[1:BOOT_MAX] STATE == HMSC_ST_IDLE)
        else $error("boot did not end in idle");
    AST_NO_REBOOT: assert property (STATE != HMSC_ST_BOOT |=> STATE != HMSC_ST_BOOT)
        else $error("boot state entered again");
    AST_FAULT_IDLE: assert property ((FAULT_FLAGS != 8'h00 && STATE != HMSC_ST_BOOT)
        |-> ##[1:3] STATE == HMSC_ST_IDLE) else $error("fault did not force idle");
    AST_FAULT_HOLD: assert property ((FAULT_FLAGS != 8'h00) [*3] |-> STATE != HMSC_ST_DRIVE)
        else $error("drive while fault stands");
    AST_FAULT_NOSTART: assert property ((FAULT_FLAGS != 8'h00 && $past(FAULT_FLAGS) != 8'h00)
        |-> !STORED_START) else $error("sequence started under fault");
    AST_START_DRIVE: assert property (STORED_START |-> ##[0:1] STATE == HMSC_ST_DRIVE)
        else $error("start without drive state");
    AST_ZERO_OFF: assert property (DRIVE.level == 16'h0000 [*2] |-> !DRIVE.enable)
        else $error("stage on at zero level");
    AST_ZC_UPDATE: assert property (($changed(DRIVE.level) && STATE == HMSC_ST_DRIVE
        && $past(STATE) == HMSC_ST_DRIVE) |-> ($past(ZERO_CROSS) || $past(ZERO_CROSS, 2)))
        else $error("level changed away from zero crossing");
    COV_STANDBY: cover property (STATE == HMSC_ST_DRIVE ##1 STATE == HMSC_ST_STANDBY);
    COV_START: cover property (STORED_START);
    COV_ENABLE: cover property ($rose(DRIVE.enable));
endmodule
bind hmsc_ctrl hmsc_ctrl_checker #(.HALF_W(HALF_W), .BOOT_CYC(BOOT_CYC)) chk (.CLK(CLK), .NRST(NRST),
    .FAULT_FLAGS(FAULT_FLAGS), .ZERO_CROSS(ZERO_CROSS), .DRIVE(DRIVE), .STATE(STATE),
    .STORED_START(STORED_START));

/* sim/hmsc_ctrl_tb_top.sv */
// Self-checking bench for the playback controller
`timescale 1ns/1ps
`include "hmsc_defs.svh"
module hmsc_ctrl_tb_top
    import hmsc_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic pin = 1'b0;
    logic [7:0] fault = 8'h00;
    logic done;
    logic zc;
    logic start;
    hmsc_drive_type drive;
    hmsc_loop_type loop;
    hmsc_state_type state;
    int fail_count = 0;
    int cmp_count = 0;
    always #20 clk = ~clk;
    hmsc_ctrl uut (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .TRIGGER_PWM_PIN(pin), .FAULT_FLAGS(fault), .STORED_DONE(done), .ZERO_CROSS(zc),
        .DRIVE(drive), .LOOP(loop), .STATE(state), .STORED_START(start));
    hmsc_stage_model model (.CLK(clk), .NRST(nrst), .STORED_START(start), .ZERO_CROSS(zc), .STORED_DONE(done));
    task automatic test_done();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp(what, exp, rdata);
    endtask
    task automatic wait_st(input hmsc_state_type exp);
        int n;
        n = 0;
        while (state !== exp && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp("state", {14'h0000, exp}, {14'h0000, state});
    endtask
    task automatic settle();
        repeat (60) @(posedge clk);
        #1;
    endtask
    initial begin
        #400000;
        fail_count++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1;
        cmp("state", {14'h0000, HMSC_ST_BOOT}, {14'h0000, state});
        wait_st(HMSC_ST_IDLE);
        rd_reg(`HMSC_REG_CTRL, `HMSC_CTRL_RESET, "ctrl");
        rd_reg(`HMSC_REG_NOMPK, {8'h00, `HMSC_NOMPK_RESET}, "nompk");
        rd_reg(`HMSC_REG_ABSPK, {8'h00, `HMSC_ABSPK_RESET}, "abspk");
        rd_reg(`HMSC_REG_HALF, 16'h11f4, "half");
        rd_reg(4'hf, 16'h0000, "unmapped");
        wr_reg(`HMSC_REG_HALF, 16'h0001);
        rd_reg(`HMSC_REG_HALF, 16'h0001, "half kept");
        for (int m = 0; m < 8; m++) begin
            if (m == 0 || m > 4) begin
                wr_reg(`HMSC_REG_CTRL, 16'(m));
                wr_reg(`HMSC_REG_GO, 16'h0001);
                settle();
                cmp("state", {14'h0000, HMSC_ST_IDLE}, {14'h0000, state});
            end
        end
        wr_reg(`HMSC_REG_CTRL, 16'h0008);
        wait_st(HMSC_ST_STANDBY);
        wr_reg(`HMSC_REG_CTRL, 16'h0003);
        wr_reg(`HMSC_REG_GO, 16'h0001);
        wait_st(HMSC_ST_DRIVE);
        wait_st(HMSC_ST_IDLE);
        wr_reg(`HMSC_REG_CTRL, 16'h000b);
        wr_reg(`HMSC_REG_GO, 16'h0001);
        wait_st(HMSC_ST_DRIVE);
        wait_st(HMSC_ST_STANDBY);
        wr_reg(`HMSC_REG_GO, 16'h0001);
        wait_st(HMSC_ST_DRIVE);
        @(posedge clk);
        fault <= 8'h04;
        wait_st(HMSC_ST_IDLE);
        wr_reg(`HMSC_REG_GO, 16'h0001);
        settle();
        cmp("state", {14'h0000, HMSC_ST_IDLE}, {14'h0000, state});
        @(posedge clk);
        fault <= 8'h00;
        wr_reg(`HMSC_REG_CTRL, 16'h0004);
        pin <= 1'b1;
        wait_st(HMSC_ST_DRIVE);
        wait_st(HMSC_ST_IDLE);
        @(posedge clk);
        pin <= 1'b0;
        settle();
        cmp("state", {14'h0000, HMSC_ST_IDLE}, {14'h0000, state});
        wr_reg(`HMSC_REG_LEVEL, 16'h007f);
        wr_reg(`HMSC_REG_CTRL, 16'h0001);
        wait_st(HMSC_ST_DRIVE);
        settle();
        cmp("level", 16'h5f40, drive.level);
        cmp("enable", 16'h0001, {15'h0000, drive.enable});
        wr_reg(`HMSC_REG_LEVEL, 16'h0080);
        settle();
        cmp("level", 16'h5f40, drive.level);
        cmp("negative", 16'h0001, {15'h0000, drive.negative});
        rd_reg(`HMSC_REG_POL, 16'h0001, "polarity");
        wr_reg(`HMSC_REG_LEVEL, 16'h0000);
        settle();
        cmp("enable", 16'h0000, {15'h0000, drive.enable});
        wr_reg(`HMSC_REG_CTRL, 16'h0011);
        wr_reg(`HMSC_REG_LEVEL, 16'h007f);
        settle();
        cmp("level", 16'h3f80, drive.level);
        cmp("enable", 16'h0001, {15'h0000, drive.enable});
        wr_reg(`HMSC_REG_LEVEL, 16'h0080);
        settle();
        cmp("level", 16'h0000, drive.level);
        wr_reg(`HMSC_REG_CTRL, 16'h03c0);
        #1;
        cmp("loop", 16'h001b, {11'h000, loop});
        wr_reg(`HMSC_REG_CTRL, 16'h0390);
        #1;
        cmp("loop", 16'h0000, {11'h000, loop});
        wait_st(HMSC_ST_IDLE);
        wr_reg(`HMSC_REG_CTRL, 16'h0002);
        repeat (6) begin
            pin <= 1'b1;
            repeat (6) @(posedge clk);
            pin <= 1'b0;
            repeat (2) @(posedge clk);
        end
        settle();
        cmp("state", {14'h0000, HMSC_ST_DRIVE}, {14'h0000, state});
        cmp("level", 16'h3000, drive.level);
        cmp("negative", 16'h0000, {15'h0000, drive.negative});
        cmp("enable", 16'h0001, {15'h0000, drive.enable});
        wr_reg(`HMSC_REG_CTRL, 16'h0000);
        test_done();
    end
endmodule
